// ---- dv/cpu_logic_stack_opcode_subset_tb_top.sv ----
// self-checking bench for the executor core
`timescale 1ns/10ps
`default_nettype none
module cpu_logic_stack_opcode_subset_tb_top
   import cpuls_pkg::*;
;
   logic i_clock = 1'b0;
   logic i_resetn = 1'b0;
   cpuls_instr_t i_instr = '0;
   logic i_debug_enter = 1'b0;
   logic i_debug_exit = 1'b0;
   logic i_break_enable = 1'b0;
   logic i_device_reset_req = 1'b0;
   logic i_break_hit = 1'b0;
   logic [7:0] i_mem_rdata;
   logic o_ready, o_done, o_illegal, o_debug_mode, o_break_enabled, o_device_reset;
   logic [7:0] o_flags, o_sp, fs;
   logic [2:0] o_fetch_cycles;
   cpuls_result_t o_result, rs;
   int fail_count = 0;
   int checks_done = 0;
   cpuls_core cpuls_core_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_instr(i_instr),
      .i_mem_rdata(i_mem_rdata), .i_debug_enter(i_debug_enter), .i_debug_exit(i_debug_exit),
      .i_break_enable(i_break_enable), .i_device_reset_req(i_device_reset_req),
      .i_break_hit(i_break_hit), .o_ready(o_ready), .o_done(o_done), .o_illegal(o_illegal),
      .o_debug_mode(o_debug_mode), .o_break_enabled(o_break_enabled),
      .o_device_reset(o_device_reset), .o_flags(o_flags), .o_sp(o_sp),
      .o_fetch_cycles(o_fetch_cycles), .o_result(o_result));
   cpuls_stack_model cpuls_stack_model_inst (.i_clock(i_clock), .i_sp(o_sp),
      .i_result(o_result), .o_rdata(i_mem_rdata));
   // ==========================================
   // helpers
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic step;
      @(posedge i_clock);
      #1;
   endtask : step
   // one instruction: snapshot after take, then count edges up to done
   task automatic issue(input logic [7:0] op, input logic pre, input logic [7:0] d,
      input logic [7:0] s, input logic [7:0] ex, input logic [2:0] fc);
      int n;
      n = 0;
      while (o_ready !== 1'b1 && n < 40)
      begin
         step();
         n++;
      end
      i_instr = '{1'b1, op, pre, d, s};
      step();
      i_instr.valid = 1'b0;
      rs = o_result;
      fs = o_flags;
      chk("fetch", {5'h00, fc}, {5'h00, o_fetch_cycles});
      n = 1;
      while (o_done !== 1'b1 && n < 20)
      begin
         step();
         n++;
      end
      chk("exec", ex, 8'(n));
   endtask : issue
   // ==========================================
   // scenarios
   task automatic t_rotate;
      logic [7:0] op [4] = '{OP_ROTL_R, OP_ROTLC_IR, OP_ROTL_IR, OP_ROTLC_R};
      logic [7:0] d [4] = '{8'h81, 8'h80, 8'h40, 8'h80};
      logic [7:0] r [4] = '{8'h03, 8'h01, 8'h80, 8'h00};
      logic [7:0] f [4] = '{8'h90, 8'h90, 8'h30, 8'hd0};
      for (int i = 0; i < 4; i++)
      begin
         issue(op[i], 1'b0, d[i], 8'h00, (i == 1 || i == 2) ? 8'h03 : 8'h02, 3'h2);
         chk("rot_data", r[i], rs.dst_data);
         chk("rot_flags", f[i], fs);
      end
   endtask : t_rotate
   task automatic t_or;
      logic [7:0] d;
      logic [7:0] s;
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
      begin
         d = (i == 5) ? 8'h00 : 8'(8'h03 << i);
         s = (i == 5) ? 8'h00 : 8'h80;
         r = (i > 5) ? 8'hff : d | s;
         if (i < 6)
            issue(OP_OR_RR + 8'(i), 1'b0, d, s, i[0] ? 8'h04 : 8'h03,
               (i < 2) ? 3'h2 : 3'h3);
         else
            issue(OP_OREXT_ER + 8'(i - 6), 1'b0, 8'h55, 8'haa, 8'h03, 3'h4);
         chk("or_data", r, rs.dst_data);
         chk("or_flags", {1'b1, r == 8'h00, r[7], 5'h00}, fs);
      end
      issue(OP_CLEAR_CARRY, 1'b0, 8'h00, 8'h00, 8'h03 - 8'h01, 3'h1);
      chk("clr_flags", 8'h20, fs);
   endtask : t_or
   task automatic t_stack;
      logic [7:0] op [7] = '{OP_PUSH_R, OP_PUSH_R, OP_PUSH_IR, OP_PUSH_EXT, OP_POP_R, OP_POP_IR,
         OP_POP_EXT};
      logic [7:0] s [7] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'hc3, 8'h5a, 8'h3c};
      logic [7:0] ex [7] = '{8'h02, 8'h02, 8'h03, 8'h02, 8'h02, 8'h03, 8'h02};
      logic [2:0] fc [7] = '{3'h2, 3'h3, 3'h2, 3'h3, 3'h2, 3'h2, 3'h3};
      logic [7:0] sp [7] = '{8'hff, 8'hfe, 8'hfd, 8'hfc, 8'hfd, 8'hfe, 8'hff};
      for (int i = 0; i < 7; i++)
      begin
         issue(op[i], i == 1, 8'h00, s[i], ex[i], fc[i]);
         chk("stack_sp", sp[i], o_sp);
         chk("stack_val", s[i], (i < 4) ? rs.mem_data : rs.dst_data);
         chk("stack_addr", (i < 4) ? sp[i] : sp[i] - 8'h01, rs.mem_addr);
         chk("stack_flags", 8'h20, fs);
      end
      issue(OP_RETURN, 1'b0, 8'h00, 8'h00, 8'h04, 3'h1);
      chk("return_sp", 8'h01, o_sp);
      chk("return_load", 8'h01, {7'h00, rs.pc_load});
      chk("return_addr", 8'hff, rs.mem_addr);
   endtask : t_stack
   // an opcode just past the extended OR pair is refused with no state change
   task automatic t_illegal;
      i_instr = '{1'b1, 8'h4a, 1'b0, 8'h12, 8'h34};
      chk("ill_ready", 8'h01, {7'h00, o_ready});
      step();
      i_instr.valid = 1'b0;
      chk("ill_pulse", 8'h01, {7'h00, o_illegal});
      chk("ill_sp", 8'h01, o_sp);
      chk("ill_flags", 8'h20, o_flags);
      chk("ill_wr", 8'h00, {7'h00, o_result.wr_dst});
      step();
      chk("ill_end", 8'h00, {7'h00, o_illegal});
   endtask : t_illegal
   task automatic t_debug;
      i_debug_enter = 1'b1;
      step();
      i_debug_enter = 1'b0;
      i_instr = '{1'b1, OP_POP_R, 1'b0, 8'h00, 8'h00};
      chk("dbg_mode", 8'h01, {7'h00, o_debug_mode});
      chk("dbg_ready", 8'h00, {7'h00, o_ready});
      step();
      chk("dbg_refuse", 8'h01, o_sp);
      i_instr.valid = 1'b0;
      i_debug_exit = 1'b1;
      i_break_enable = 1'b1;
      step();
      i_debug_exit = 1'b0;
      i_break_hit = 1'b1;
      chk("break_en", 8'h01, {7'h00, o_break_enabled});
      chk("dbg_left", 8'h00, {7'h00, o_debug_mode});
      step();
      i_break_hit = 1'b0;
      i_device_reset_req = 1'b1;
      chk("break_dbg", 8'h01, {7'h00, o_debug_mode});
      step();
      i_device_reset_req = 1'b0;
      chk("dev_rst", 8'h01, {7'h00, o_device_reset});
   endtask : t_debug
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // ==========================================
   // clock, watchdog, main sequence
   initial
   begin
      forever #20 i_clock = ~i_clock;
   end
   initial
   begin
      #100000;
      fail_count++;
      end_of_test();
   end
   initial
   begin
      repeat (10) @(posedge i_clock);
      #1;
      i_resetn = 1'b1;
      t_rotate();
      t_or();
      t_stack();
      t_illegal();
      t_debug();
      end_of_test();
   end
endmodule : cpu_logic_stack_opcode_subset_tb_top
`default_nettype wire

// ---- dv/cpuls_core_monitor.sv ----
// concurrent checks on the executor core ports
`timescale 1ns/10ps
`default_nettype none
module cpuls_core_monitor
   import cpuls_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // observed inputs
   input wire cpuls_instr_t i_instr,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_device_reset_req,
   // observed outputs
   input wire logic o_ready,
   input wire logic o_done,
   input wire logic o_device_reset,
   input wire logic [7:0] o_flags,
   input wire logic [7:0] o_sp,
   input wire logic [2:0] o_fetch_cycles,
   input wire cpuls_result_t o_result
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   // ==========================================
   // accepted request
   logic take;
   logic any;
   assign any = i_instr.valid && o_ready;
   assign take = any && !i_instr.prefixed;
   // ==========================================
   // checks
   or_value_a: assert property (
      take && i_instr.opcode == OP_OR_RR |=> o_result.wr_dst && !o_flags[FLAG_V]
      && o_result.dst_data == ($past(i_instr.dst) | $past(i_instr.src)))
      else $error("or result or overflow wrong");
   or_timing_a: assert property (take && i_instr.opcode == OP_OR_RIR |-> ##4 o_done)
      else $error("indirect or done late or early");
   or_ext_fetch_a: assert property (
      take && i_instr.opcode == OP_OREXT_ER |=> o_fetch_cycles == 3'h4 && !o_flags[FLAG_V])
      else $error("extended or fetch count wrong");
   pop_stack_a: assert property (
      take && i_instr.opcode == OP_POP_R |=> o_sp == $past(o_sp) + SP_STEP
      && o_result.dst_data == $past(i_mem_rdata) && $stable(o_flags))
      else $error("pop data or pointer wrong");
   pop_ext_stack_a: assert property (
      take && i_instr.opcode == OP_POP_EXT |=> o_sp == $past(o_sp) + SP_STEP && $stable(o_flags))
      else $error("extended pop pointer wrong");
   push_stack_a: assert property (
      any && i_instr.opcode == OP_PUSH_R |=> o_sp == $past(o_sp) - SP_STEP
      && o_result.mem_wr && o_result.mem_addr == o_sp && $stable(o_flags))
      else $error("push pointer or store wrong");
   push_ext_stack_a: assert property (
      take && i_instr.opcode == OP_PUSH_EXT |=> o_sp == $past(o_sp) - SP_STEP ##1 o_done)
      else $error("extended push wrong");
   return_reload_a: assert property (
      take && i_instr.opcode == OP_RETURN |=> o_result.pc_load
      && o_sp == $past(o_sp) + SP_RET_STEP ##3 o_done)
      else $error("return reload wrong");
   dev_reset_a: assert property (i_device_reset_req |=> o_device_reset)
      else $error("device reset not raised");
   clear_carry_a: assert property (
      take && i_instr.opcode == OP_CLEAR_CARRY |=> !o_flags[FLAG_C]
      && o_flags[6:0] == $past(o_flags[6:0]))
      else $error("carry clear wrong");
endmodule : cpuls_core_monitor
bind cpuls_core cpuls_core_monitor cpuls_core_monitor_inst (
   .i_clock(i_clock), .i_resetn(i_resetn), .i_instr(i_instr), .i_mem_rdata(i_mem_rdata),
   .i_device_reset_req(i_device_reset_req), .o_ready(o_ready), .o_done(o_done),
   .o_device_reset(o_device_reset), .o_flags(o_flags), .o_sp(o_sp),
   .o_fetch_cycles(o_fetch_cycles), .o_result(o_result)
);
`default_nettype wire

// ---- dv/cpuls_stack_model.sv ----
// stack memory standing in for the data memory beside the core
`timescale 1ns/10ps
`default_nettype none
module cpuls_stack_model
   import cpuls_pkg::*;
(
   // clock
   input wire logic i_clock,
   // core side
   input wire logic [7:0] i_sp,
   input wire cpuls_result_t i_result,
   // stack read
   output logic [7:0] o_rdata
);
   // unwritten bytes read as unknown, so a pop of an empty slot shows up
   logic [7:0] mem [0:255];
   assign o_rdata = mem[i_sp];
   always_ff @(posedge i_clock)
      if (i_result.mem_wr)
         mem[i_result.mem_addr] <= i_result.mem_data;
endmodule : cpuls_stack_model
`default_nettype wire

// ---- hw/cpuls_core.sv ----
// logic, stack and rotate instruction executor with debug control
// How it works
// - opcodes 42h-47h store dst OR src; fetch 2,2,3,3,3,3 and execute 3,4,3,4,3,4.
// - opcodes 48h and 49h do the extended OR in 4 fetch and 3 execute cycles with OR flags.
// - opcodes 50h and 51h load dst from the stack byte, then raise the pointer by one.
// - opcode D8h pops into an extended dst and raises the pointer by one, flags kept.
// - opcodes 70h, 71h and prefixed 70h lower the pointer by one and store src there.
// - opcode C8h lowers the pointer and stores an extended source, flags kept.
// - opcode AFh reloads the program counter from the stack and adds two to the pointer.
// - OR sets zero and sign from the result, clears overflow, keeps C, D and H.
// - the debugger can enter or leave debug mode, enable breakpoints and request a device reset.
`timescale 1ns/10ps
`default_nettype none
module cpuls_core
   import cpuls_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // instruction from fetch unit
   input wire cpuls_instr_t i_instr,
   input wire logic [7:0] i_mem_rdata,
   // debug control
   input wire logic i_debug_enter,
   input wire logic i_debug_exit,
   input wire logic i_break_enable,
   input wire logic i_device_reset_req,
   input wire logic i_break_hit,
   // status
   output logic o_ready,
   output logic o_done,
   output logic o_illegal,
   output logic o_debug_mode,
   output logic o_break_enabled,
   output logic o_device_reset,
   output logic [7:0] o_flags,
   output logic [7:0] o_sp,
   output logic [2:0] o_fetch_cycles,
   output var cpuls_result_t o_result
);

   // ==========================================
   // reset release
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================
   // decoder
   cpuls_dec_t dec;
   cpuls_decode u_decode (
      .i_opcode(i_instr.opcode),
      .i_prefixed(i_instr.prefixed),
      .o_dec(dec)
   );

   // ==========================================
   // state
   typedef enum logic [1:0] {
      CPULS_IDLE = 2'b01,
      CPULS_EXEC = 2'b10
   } cpuls_state_t;

   cpuls_state_t state, next_state;
   logic [2:0] count, next_count;
   logic [7:0] flags, next_flags;
   logic [7:0] sp, next_sp;
   cpuls_result_t result, next_result;
   logic done, next_done;
   logic illegal, next_illegal;
   logic [2:0] fetch_cycles, next_fetch_cycles;
   logic dbg, next_dbg;
   logic break_en, next_break_en;
   logic dev_rst, next_dev_rst;
   logic [7:0] res;
   logic [7:0] rot;
   logic rot_c;

   always_comb
   begin
      next_state = state;
      next_count = count;
      next_flags = flags;
      next_sp = sp;
      next_result = result;
      next_done = 1'b0;
      next_illegal = 1'b0;
      next_fetch_cycles = fetch_cycles;
      next_dbg = dbg;
      next_break_en = break_en;
      next_dev_rst = 1'b0;
      res = i_instr.dst | i_instr.src;
      rot_c = i_instr.dst[7];
      rot = {i_instr.dst[6:0], dec.through_carry ? flags[FLAG_C] : i_instr.dst[7]};
      if (i_debug_enter || (i_break_hit && break_en))
         next_dbg = 1'b1;
      else if (i_debug_exit)
         next_dbg = 1'b0;
      next_break_en = i_break_enable;
      next_dev_rst = i_device_reset_req;
      case (state)
         CPULS_IDLE:
         begin
            next_result.wr_dst = 1'b0;
            next_result.mem_wr = 1'b0;
            next_result.pc_load = 1'b0;
            if (i_instr.valid && !dbg)
            begin
               if (!dec.known)
                  next_illegal = 1'b1;
               else
               begin
                  next_fetch_cycles = dec.fetch_cycles;
                  next_count = dec.exec_cycles - CYC_ONE;
                  next_state = CPULS_EXEC;
                  case (dec.op)
                     CPULS_OP_OR:
                     begin
                        next_result.wr_dst = 1'b1;
                        next_result.dst_data = res;
                        next_flags[FLAG_Z] = (res == 8'h00);
                        next_flags[FLAG_S] = res[7];
                        next_flags[FLAG_V] = 1'b0;
                     end
                     CPULS_OP_POP:
                     begin
                        next_result.wr_dst = 1'b1;
                        next_result.dst_data = i_mem_rdata;
                        next_result.mem_addr = sp;
                        next_sp = sp + SP_STEP;
                     end
                     CPULS_OP_PUSH:
                     begin
                        next_sp = sp - SP_STEP;
                        next_result.mem_wr = 1'b1;
                        next_result.mem_addr = sp - SP_STEP;
                        next_result.mem_data = i_instr.src;
                     end
                     CPULS_OP_RETURN:
                     begin
                        next_result.pc_load = 1'b1;
                        next_result.mem_addr = sp;
                        next_sp = sp + SP_RET_STEP;
                     end
                     CPULS_OP_CLRC:
                        next_flags[FLAG_C] = 1'b0;
                     CPULS_OP_ROT:
                     begin
                        next_result.wr_dst = 1'b1;
                        next_result.dst_data = rot;
                        next_flags[FLAG_C] = rot_c;
                        next_flags[FLAG_Z] = (rot == 8'h00);
                        next_flags[FLAG_S] = rot[7];
                        next_flags[FLAG_V] = rot[7] ^ i_instr.dst[7];
                     end
                     default: next_state = CPULS_EXEC;
                  endcase
               end
            end
         end
         CPULS_EXEC:
         begin
            // strobes last one cycle; the rest are execute wait states
            next_result.wr_dst = 1'b0;
            next_result.mem_wr = 1'b0;
            next_result.pc_load = 1'b0;
            if (count == CYC_ONE || count == CYC_ZERO)
            begin
               next_state = CPULS_IDLE;
               next_done = 1'b1;
            end
            else
               next_count = count - CYC_ONE;
         end
         default: next_state = CPULS_IDLE;
      endcase
   end

   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= CPULS_IDLE;
         count <= CYC_ZERO;
         flags <= FLAGS_RESET;
         sp <= SP_RESET;
         result <= '0;
         done <= 1'b0;
         illegal <= 1'b0;
         fetch_cycles <= CYC_ZERO;
         dbg <= 1'b0;
         break_en <= 1'b0;
         dev_rst <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         flags <= next_flags;
         sp <= next_sp;
         result <= next_result;
         done <= next_done;
         illegal <= next_illegal;
         fetch_cycles <= next_fetch_cycles;
         dbg <= next_dbg;
         break_en <= next_break_en;
         dev_rst <= next_dev_rst;
      end
   end

   // ==========================================
   // outputs
   // held low until the internal reset is released, so no request is lost in reset
   assign o_ready = (state == CPULS_IDLE) && !dbg && rst_n;
   assign o_done = done;
   assign o_illegal = illegal;
   assign o_debug_mode = dbg;
   assign o_break_enabled = break_en;
   assign o_device_reset = dev_rst;
   assign o_flags = flags;
   assign o_sp = sp;
   assign o_fetch_cycles = fetch_cycles;
   assign o_result = result;

endmodule : cpuls_core
`default_nettype wire

// ---- hw/cpuls_decode.sv ----
// opcode decoder: class, forms and cycle counts
`timescale 1ns/10ps
`default_nettype none
module cpuls_decode
   import cpuls_pkg::*;
(
   // instruction
   input wire logic [7:0] i_opcode,
   input wire logic i_prefixed,
   // decoded
   output var cpuls_dec_t o_dec
);

   function automatic cpuls_dec_t mk(cpuls_op_t op, logic thr, logic ext,
                                     logic [2:0] f, logic [2:0] e);
      cpuls_dec_t d;
      d.op = op;
      d.through_carry = thr;
      d.extended = ext;
      d.fetch_cycles = f;
      d.exec_cycles = e;
      d.known = 1'b1;
      return d;
   endfunction : mk

   always_comb
   begin
      o_dec = mk(CPULS_OP_NONE, 1'b0, 1'b0, CYC_ZERO, CYC_ZERO);
      o_dec.known = 1'b0;
      if (i_prefixed)
      begin
         if (i_opcode == OP_PUSH_R)
            o_dec = mk(CPULS_OP_PUSH, 1'b0, 1'b0, CYC_THREE, CYC_TWO);
      end
      else
      begin
         case (i_opcode)
            OP_OR_RR: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b0, CYC_TWO, CYC_THREE);
            OP_OR_RIR: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b0, CYC_TWO, CYC_FOUR);
            OP_OR_RGRG: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b0, CYC_THREE, CYC_THREE);
            OP_OR_RGIR: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b0, CYC_THREE, CYC_FOUR);
            OP_OR_RGIM: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b0, CYC_THREE, CYC_THREE);
            OP_OR_IRIM: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b0, CYC_THREE, CYC_FOUR);
            OP_OREXT_ER: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b1, CYC_FOUR, CYC_THREE);
            OP_OREXT_IM: o_dec = mk(CPULS_OP_OR, 1'b0, 1'b1, CYC_FOUR, CYC_THREE);
            OP_POP_R: o_dec = mk(CPULS_OP_POP, 1'b0, 1'b0, CYC_TWO, CYC_TWO);
            OP_POP_IR: o_dec = mk(CPULS_OP_POP, 1'b0, 1'b0, CYC_TWO, CYC_THREE);
            OP_POP_EXT: o_dec = mk(CPULS_OP_POP, 1'b0, 1'b1, CYC_THREE, CYC_TWO);
            OP_PUSH_R: o_dec = mk(CPULS_OP_PUSH, 1'b0, 1'b0, CYC_TWO, CYC_TWO);
            OP_PUSH_IR: o_dec = mk(CPULS_OP_PUSH, 1'b0, 1'b0, CYC_TWO, CYC_THREE);
            OP_PUSH_EXT: o_dec = mk(CPULS_OP_PUSH, 1'b0, 1'b1, CYC_THREE, CYC_TWO);
            OP_RETURN: o_dec = mk(CPULS_OP_RETURN, 1'b0, 1'b0, CYC_ONE, CYC_FOUR);
            OP_CLEAR_CARRY: o_dec = mk(CPULS_OP_CLRC, 1'b0, 1'b0, CYC_ONE, CYC_TWO);
            OP_ROTL_R: o_dec = mk(CPULS_OP_ROT, 1'b0, 1'b0, CYC_TWO, CYC_TWO);
            OP_ROTL_IR: o_dec = mk(CPULS_OP_ROT, 1'b0, 1'b0, CYC_TWO, CYC_THREE);
            OP_ROTLC_R: o_dec = mk(CPULS_OP_ROT, 1'b1, 1'b0, CYC_TWO, CYC_TWO);
            OP_ROTLC_IR: o_dec = mk(CPULS_OP_ROT, 1'b1, 1'b0, CYC_TWO, CYC_THREE);
            default: o_dec.known = 1'b0;
         endcase
      end
   end

endmodule : cpuls_decode
`default_nettype wire

// ---- inc/cpuls_pkg.sv ----
// shared constants and types for the logic and stack instruction decoder
package cpuls_pkg;

   // ==========================================
   // opcodes
   localparam logic [7:0] OP_OR_RR = 8'h42;
   localparam logic [7:0] OP_OR_RIR = 8'h43;
   localparam logic [7:0] OP_OR_RGRG = 8'h44;
   localparam logic [7:0] OP_OR_RGIR = 8'h45;
   localparam logic [7:0] OP_OR_RGIM = 8'h46;
   localparam logic [7:0] OP_OR_IRIM = 8'h47;
   localparam logic [7:0] OP_OREXT_ER = 8'h48;
   localparam logic [7:0] OP_OREXT_IM = 8'h49;
   localparam logic [7:0] OP_POP_R = 8'h50;
   localparam logic [7:0] OP_POP_IR = 8'h51;
   localparam logic [7:0] OP_POP_EXT = 8'hd8;
   localparam logic [7:0] OP_PUSH_R = 8'h70;
   localparam logic [7:0] OP_PUSH_IR = 8'h71;
   localparam logic [7:0] OP_PREFIX = 8'h1f;
   localparam logic [7:0] OP_PUSH_EXT = 8'hc8;
   localparam logic [7:0] OP_CLEAR_CARRY = 8'hcf;
   localparam logic [7:0] OP_RETURN = 8'haf;
   localparam logic [7:0] OP_ROTL_R = 8'h90;
   localparam logic [7:0] OP_ROTL_IR = 8'h91;
   localparam logic [7:0] OP_ROTLC_R = 8'h10;
   localparam logic [7:0] OP_ROTLC_IR = 8'h11;

   // ==========================================
   // flag bit positions
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;

   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] SP_RESET = 8'h00;
   localparam logic [7:0] SP_STEP = 8'h01;
   localparam logic [7:0] SP_RET_STEP = 8'h02;
   localparam logic [2:0] CYC_ZERO = 3'h0;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR = 3'h4;

   // ==========================================
   // operation classes
   typedef enum logic [6:0] {
      CPULS_OP_NONE = 7'h01,
      CPULS_OP_OR = 7'h02,
      CPULS_OP_POP = 7'h04,
      CPULS_OP_PUSH = 7'h08,
      CPULS_OP_RETURN = 7'h10,
      CPULS_OP_CLRC = 7'h20,
      CPULS_OP_ROT = 7'h40
   } cpuls_op_t;

   typedef struct packed {
      cpuls_op_t op;
      logic through_carry;
      logic extended;
      logic [2:0] fetch_cycles;
      logic [2:0] exec_cycles;
      logic known;
   } cpuls_dec_t;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic prefixed;
      logic [7:0] dst;
      logic [7:0] src;
   } cpuls_instr_t;

   typedef struct packed {
      logic wr_dst;
      logic [7:0] dst_data;
      logic mem_wr;
      logic [7:0] mem_addr;
      logic [7:0] mem_data;
      logic pc_load;
   } cpuls_result_t;

endpackage : cpuls_pkg
